// >>> logic/cpu_operand_address_and_sequencer.sv
// operand address generation and special operation sequencer of the cpu core
//
// Overview of operation
// - direct mode: zero high byte plus byte
// - extended mode: two bytes, high first
// - plain indexed: index pair is the address
// - indexed post increment: step pair after fetch
// - index pair plus unsigned byte offset
// - pair plus byte offset, then pair increments
// - index pair plus sixteen bit offset
// - stack pointer plus unsigned byte offset
// - stack pointer plus sixteen bit offset
// - reset abandons activity at once
// - after reset, six cycle vector fetch
// - interrupt waits for instruction end
// - vector from top pending request at entry
// - push pc low, pc high, x, a, flags
// - set mask, vector high, low, idle, three fetches
// - upper index byte is never pushed
// - software trap uses entry, ignores mask
// - wait clears mask, gates clocks until wake
// - debug command in wait enters background
// - debug enable keeps oscillator on in stop
// - background instruction halts until resume command
// - no interrupt right after mask clear
module cpu_operand_address_and_sequencer (
	input wire logic clock, // bus clock, 250 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic rst_src_done, // internal reset source check finished
	input wire logic rst_pin_n, // external reset pin, active low
	input wire seq_pkg::addr_mode_t mode, // operand addressing mode
	input wire logic [15:0] index_pair, // index register pair
	input wire logic [15:0] stack_ptr, // stack pointer
	input wire logic [15:0] operand_bytes, // operand bytes, high first
	output logic [15:0] operand_addr, // formed operand address
	input wire logic operand_fetched, // operand access completed
	output logic index_load, // load index_pair_next into the pair
	output logic [15:0] index_pair_next, // incremented index pair
	input wire logic [7:0] program_counter_low_byte, // return address low
	input wire logic [7:0] program_counter_upper_byte, // return address high
	input wire logic [7:0] index_low, // low index byte
	input wire logic [7:0] accumulator, // accumulator
	input wire logic [7:0] condition_code_reg, // flags
	input wire logic instr_boundary, // current instruction has finished
	input wire logic irq_pending, // some hardware request pending
	input wire logic [15:0] irq_vector_addr, // vector of top pending request
	input wire logic software_trap_instruction, // trap opcode at boundary
	input wire logic wait_instruction, // wait opcode at boundary
	input wire logic stop_instruction, // stop opcode at boundary
	input wire logic enter_debug_instruction, // background opcode at boundary
	input wire logic mask_cleared_prev, // last instruction cleared the mask
	input wire logic debug_enable_bit, // debug enable from serial interface
	input wire logic reset_into_debug, // reset was into background mode
	input wire logic debug_serial_pin_cmd, // serial background command, pulse
	input wire logic resume_cmd, // go command, pulse
	input wire logic single_step_command, // trace one command, pulse
	input wire logic tagged_resume_command, // tagged go command, pulse
	input wire logic [7:0] bus_rdata, // read data from memory
	output logic bus_req, // bus cycle active
	output logic bus_we, // bus cycle is a write
	output logic [15:0] bus_addr, // bus cycle address
	output logic [7:0] bus_wdata, // bus write data
	output logic [15:0] stack_ptr_next, // stack pointer after pushes
	output logic stack_load, // load stack_ptr_next
	output logic [15:0] pc_load_value, // new program counter
	output logic pc_load, // load pc_load_value, pulse
	output logic set_imask, // set interrupt mask, pulse
	output logic clear_imask, // clear interrupt mask, pulse
	output logic cpu_clk_gate, // cpu clocks stopped when high
	output logic osc_keep_on, // keep oscillator running in stop
	output logic in_background, // active background mode
	output logic running // executing user instructions
);
	////////////////////////////////////////////////////////////////////////////
	// sequencer states
	typedef enum logic [3:0] {
		st_reset = 4'h0,
		st_vec_fetch = 4'h1,
		st_run = 4'h2,
		st_push = 4'h3,
		st_mask = 4'h4,
		st_vhi = 4'h5,
		st_vlo = 4'h6,
		st_free = 4'h7,
		st_fill = 4'h8,
		st_wait = 4'h9,
		st_stop = 4'ha,
		st_bdm = 4'hb
	} seq_state_t;

	seq_state_t state_q, state_d; // sequencer state
	logic [2:0] cnt; // step count within a sequence
	logic cnt_clear; // restart counter
	logic [15:0] vec_q; // latched vector address
	logic [7:0] vhi_q; // vector high byte read
	logic [15:0] target_q; // vector target
	logic [15:0] sp_q; // working stack pointer
	logic rst_pin_s1_q, rst_pin_s2_q; // pin synchroniser
	logic src_s1_q, src_s2_q; // check-done synchroniser
	logic [7:0] push_data; // byte for the current push

	////////////////////////////////////////////////////////////////////////////
	// operand address former
	addr_if aif ();
	assign aif.mode = mode;
	assign aif.index_pair = index_pair;
	assign aif.stack_ptr = stack_ptr;
	assign aif.operand_bytes = operand_bytes;
	addr_former u_former (
		.a(aif)
	);
	assign operand_addr = aif.ea;
	// the pair steps only once the operand fetch is done
	assign index_load = aif.index_wr && operand_fetched && (state_q == st_run);
	assign index_pair_next = aif.index_next;

	step_counter #(.width(3)) u_cnt (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(cnt_clear),
		.step(1'b1),
		.count(cnt)
	);

	////////////////////////////////////////////////////////////////////////////
	// reset release: pin and check-done come from outside, so synchronise
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pin_s1_q <= 1'b0;
			rst_pin_s2_q <= 1'b0;
			src_s1_q <= 1'b0;
			src_s2_q <= 1'b0;
		end else begin
			rst_pin_s1_q <= rst_pin_n;
			rst_pin_s2_q <= rst_pin_s1_q;
			src_s1_q <= rst_src_done;
			src_s2_q <= src_s1_q;
		end
	end
	wire reset_done = rst_pin_s2_q && src_s2_q;

	////////////////////////////////////////////////////////////////////////////
	// decode of events at the instruction boundary
	wire imask = condition_code_reg[seq_pkg::imask_bit];
	// a request right after a mask clear is held off one boundary
	wire irq_take = irq_pending && !imask && !mask_cleared_prev;
	wire at_edge = (state_q == st_run) && instr_boundary;
	wire go_irq = at_edge && irq_take;
	wire go_trap = at_edge && !irq_take && software_trap_instruction;
	wire go_wait = at_edge && !irq_take && wait_instruction;
	wire go_stop = at_edge && !irq_take && stop_instruction;
	wire go_bdm = at_edge && !irq_take && enter_debug_instruction;
	wire any_resume = resume_cmd || single_step_command || tagged_resume_command;
	wire wait_wake = irq_pending; // mask was cleared on wait entry
	wire stop_bdm = debug_serial_pin_cmd && osc_keep_on;

	////////////////////////////////////////////////////////////////////////////
	// push bytes in order: pc low, pc high, index low, accumulator, flags
	// the upper index byte is left for the service routine to save
	assign push_data = (cnt == 3'h0) ? program_counter_low_byte :
		(cnt == 3'h1) ? program_counter_upper_byte :
		(cnt == 3'h2) ? index_low :
		(cnt == 3'h3) ? accumulator : condition_code_reg;
	localparam logic [2:0] push_last = 3'h4; // fifth push
	localparam logic [2:0] vec_last = 3'(seq_pkg::reset_fetch_cycles - 1);
	localparam logic [2:0] fill_last = 3'(seq_pkg::queue_fill_bytes - 1);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_d = state_q;
		cnt_clear = 1'b0;
		unique case (state_q)
			st_reset: begin
				cnt_clear = 1'b1;
				if (reset_done) state_d = st_vec_fetch;
			end
			st_vec_fetch: begin
				if (cnt == vec_last) begin
					state_d = reset_into_debug ? st_bdm : st_run;
				end
			end
			st_run: begin
				cnt_clear = 1'b1;
				if (go_irq || go_trap) state_d = st_push;
				else if (go_wait) state_d = st_wait;
				else if (go_stop) state_d = st_stop;
				else if (go_bdm) state_d = st_bdm;
			end
			st_push: begin
				if (cnt == push_last) begin
					state_d = st_mask;
				end
			end
			st_mask: state_d = st_vhi;
			st_vhi: state_d = st_vlo;
			st_vlo: state_d = st_free;
			st_free: begin
				cnt_clear = 1'b1;
				state_d = st_fill;
			end
			st_fill: begin
				if (cnt == fill_last) state_d = st_run;
			end
			st_wait: begin
				cnt_clear = 1'b1;
				if (debug_serial_pin_cmd) state_d = st_bdm;
				else if (wait_wake) state_d = st_push;
			end
			st_stop: begin
				cnt_clear = 1'b1;
				if (stop_bdm) state_d = st_bdm;
				else if (irq_pending) state_d = st_push;
			end
			st_bdm: begin
				cnt_clear = 1'b1;
				if (any_resume) state_d = st_run;
			end
			default: state_d = st_reset;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state and vector registers; reset drops everything at once
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) state_q <= st_reset;
		else state_q <= state_d;
	end

	// the vector is frozen when the entry sequence starts
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) vec_q <= 16'h0000;
		else if (state_d == st_push && state_q != st_push) begin
			vec_q <= irq_vector_addr;
		end
	end

	// working stack pointer, one down per push
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) sp_q <= 16'h0000;
		else if (state_q != st_push) sp_q <= stack_ptr;
		else sp_q <= 16'(sp_q - 16'h0001);
	end

	// vector bytes and target
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			vhi_q <= 8'h00;
			target_q <= 16'h0000;
		end else begin
			if (state_q == st_vhi) vhi_q <= bus_rdata;
			if (state_q == st_vlo) target_q <= {vhi_q, bus_rdata};
			if (state_q == st_vec_fetch && cnt == 3'h0) vhi_q <= bus_rdata;
			if (state_q == st_vec_fetch && cnt == 3'h1) target_q <= {vhi_q, bus_rdata};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus cycles of each sequence
	wire [15:0] fill_addr = 16'(target_q + {13'h0000, cnt});
	wire vec_rd_hi = (state_q == st_vec_fetch) && (cnt == 3'h0);
	wire vec_rd_lo = (state_q == st_vec_fetch) && (cnt == 3'h1);
	wire vec_fill = (state_q == st_vec_fetch) && (cnt >= 3'h2) && (cnt <= 3'h4);
	wire [15:0] rst_fill_addr = 16'(target_q + {13'h0000, 3'(cnt - 3'h2)});
	assign bus_req = (state_q == st_push) || (state_q == st_vhi) || (state_q == st_vlo) ||
		(state_q == st_fill) || vec_rd_hi || vec_rd_lo || vec_fill;
	assign bus_we = (state_q == st_push);
	assign bus_wdata = (state_q == st_push) ? push_data : 8'h00;
	assign bus_addr = (state_q == st_push) ? sp_q :
		(state_q == st_vhi) ? vec_q :
		(state_q == st_vlo) ? 16'(vec_q + 16'h0001) :
		(state_q == st_fill) ? fill_addr :
		vec_rd_hi ? seq_pkg::reset_vec_high_addr :
		vec_rd_lo ? seq_pkg::reset_vec_low_addr :
		vec_fill ? rst_fill_addr : 16'h0000;
	assign stack_ptr_next = 16'(sp_q - 16'h0001);
	assign stack_load = (state_q == st_push);
	assign pc_load = ((state_q == st_free) || (state_q == st_vec_fetch && cnt == vec_last));
	assign pc_load_value = target_q;
	assign set_imask = (state_q == st_mask);
	assign clear_imask = go_wait;
	assign cpu_clk_gate = (state_q == st_wait) || (state_q == st_stop);
	assign osc_keep_on = debug_enable_bit || reset_into_debug;
	assign in_background = (state_q == st_bdm);
	assign running = (state_q == st_run);

	////////////////////////////////////////////////////////////////////////////
	// checks
	push_order_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_push && cnt == 3'h0) |-> bus_wdata == program_counter_low_byte
		##1 bus_wdata == program_counter_upper_byte ##1 bus_wdata == index_low
		##1 bus_wdata == accumulator ##1 bus_wdata == condition_code_reg)
		else $error("push order wrong");
	entry_tail_a: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(state_q == st_push) |-> set_imask ##1 bus_req ##1 bus_req
		##1 !bus_req ##1 bus_req[*3])
		else $error("entry tail wrong");
	reset_fetch_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_reset && reset_done) |=> bus_addr == seq_pkg::reset_vec_high_addr
		##1 bus_addr == seq_pkg::reset_vec_low_addr ##4 pc_load
		##1 state_q != st_vec_fetch)
		else $error("reset fetch wrong");
	direct_page_a: assert property (@(posedge clock) disable iff (sys_rst)
		mode == seq_pkg::mode_dir |-> operand_addr[15:8] == seq_pkg::direct_page_high)
		else $error("direct page high byte not zero");
	postinc_a: assert property (@(posedge clock) disable iff (sys_rst)
		index_load |-> index_pair_next == 16'(index_pair + 16'h0001))
		else $error("post increment wrong");
	cli_guard_a: assert property (@(posedge clock) disable iff (sys_rst)
		(at_edge && mask_cleared_prev && !software_trap_instruction) |=> state_q != st_push)
		else $error("interrupt after mask clear");
	wait_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		go_wait |-> clear_imask ##1 cpu_clk_gate)
		else $error("wait entry wrong");
	bdm_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(in_background && !any_resume) |=> in_background)
		else $error("background left without resume");
	wait_bdm_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_wait && debug_serial_pin_cmd) |=> in_background && !cpu_clk_gate)
		else $error("background command in wait ignored");

	trap_unmasked_a: assert property (@(posedge clock) disable iff (sys_rst)
		(at_edge && software_trap_instruction && imask) |=> state_q == st_push)
		else $error("trap blocked by mask");

	wait_wake_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_wait && irq_pending && !debug_serial_pin_cmd) |=> state_q == st_push)
		else $error("wait not woken");

	push_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_push && cnt != seq_pkg::cnt_zero) |->
		bus_addr == 16'($past(bus_addr) - 16'h0001))
		else $error("push address not stepping");

	stop_bdm_a: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == st_stop && debug_serial_pin_cmd && osc_keep_on) |=> in_background)
		else $error("background command in stop ignored");

	boundary_only_a: assert property (@(posedge clock) disable iff (sys_rst)
		(running && !instr_boundary) |=> running)
		else $error("run left mid instruction");
endmodule : cpu_operand_address_and_sequencer

// >>> logic/seq_pkg.sv
// shared constants and types for the operand address and sequencer block
package seq_pkg;
	localparam logic [7:0] direct_page_high = 8'h00; // implied high byte
	localparam logic [15:0] reset_vec_high_addr = 16'hfffe; // start vector, high byte
	localparam logic [15:0] reset_vec_low_addr = 16'hffff; // start vector, low byte
	localparam logic [15:0] post_inc_step = 16'h0001; // index step after fetch
	localparam int reset_fetch_cycles = 6; // start sequence length
	localparam int queue_fill_bytes = 3; // bytes fetched at the vector target
	localparam int imask_bit = 3; // interrupt mask position in the flags
	localparam logic [2:0] cnt_one = 3'h1; // counter step
	localparam logic [2:0] cnt_zero = 3'h0; // counter start

	// operand addressing modes
	typedef enum logic [3:0] {
		mode_dir = 4'h0,
		mode_ext = 4'h1,
		mode_ix = 4'h2,
		mode_ix_inc = 4'h3,
		mode_ix1 = 4'h4,
		mode_ix1_inc = 4'h5,
		mode_ix2 = 4'h6,
		mode_sp1 = 4'h7,
		mode_sp2 = 4'h8
	} addr_mode_t;

	// bus cycle kinds the sequencer issues
	typedef enum logic [1:0] {
		cyc_idle = 2'h0,
		cyc_read = 2'h1,
		cyc_write = 2'h2
	} cyc_kind_t;
endpackage : seq_pkg

// >>> logic/addr_if.sv
// operand address request and result between the sequencer and the address unit
interface addr_if;
	seq_pkg::addr_mode_t mode; // selected addressing mode
	logic [15:0] index_pair; // index register pair
	logic [15:0] stack_ptr; // stack pointer
	logic [15:0] operand_bytes; // instruction bytes, high byte first
	logic [15:0] ea; // formed operand address
	logic [15:0] index_next; // index pair after the access
	logic index_wr; // index pair changes after the fetch

	modport requester (output mode, index_pair, stack_ptr, operand_bytes,
		input ea, index_next, index_wr);
	modport former (input mode, index_pair, stack_ptr, operand_bytes,
		output ea, index_next, index_wr);
endinterface : addr_if

// >>> logic/addr_former.sv
// combinational operand address former for direct, extended and indexed modes
module addr_former (
	addr_if.former a // address request and result
);
	wire [7:0] low_byte = a.operand_bytes[7:0]; // short offset or direct byte
	wire [15:0] short_off = {8'h00, low_byte}; // unsigned extension
	// all sums drop the carry so they wrap inside the 64 kB space
	wire [15:0] ix_short = 16'(a.index_pair + short_off);
	wire [15:0] ix_long = 16'(a.index_pair + a.operand_bytes);
	wire [15:0] sp_short = 16'(a.stack_ptr + short_off);
	wire [15:0] sp_long = 16'(a.stack_ptr + a.operand_bytes);
	wire [15:0] ix_plus = 16'(a.index_pair + seq_pkg::post_inc_step);

	// mode selection
	assign a.ea =
		(a.mode == seq_pkg::mode_dir) ? {seq_pkg::direct_page_high, low_byte} :
		(a.mode == seq_pkg::mode_ext) ? a.operand_bytes :
		(a.mode == seq_pkg::mode_ix) ? a.index_pair :
		(a.mode == seq_pkg::mode_ix_inc) ? a.index_pair :
		(a.mode == seq_pkg::mode_ix1) ? ix_short :
		(a.mode == seq_pkg::mode_ix1_inc) ? ix_short :
		(a.mode == seq_pkg::mode_ix2) ? ix_long :
		(a.mode == seq_pkg::mode_sp1) ? sp_short :
		(a.mode == seq_pkg::mode_sp2) ? sp_long :
		a.index_pair;
	// only the two post increment modes step the pair
	assign a.index_wr = (a.mode == seq_pkg::mode_ix_inc) ||
		(a.mode == seq_pkg::mode_ix1_inc);
	assign a.index_next = ix_plus;
endmodule : addr_former

// >>> logic/step_counter.sv
// small cycle counter used to pace fixed-length bus sequences
module step_counter #(
	parameter int width = 3 // counter width
) (
	input wire logic clock, // bus clock
	input wire logic sys_rst, // async reset, active high
	input wire logic clear, // restart at zero
	input wire logic step, // advance one
	output logic [width-1:0] count // current count
);
	if (width < 3) begin : g_width_check
		$error("step_counter width too small");
	end
	logic [width-1:0] count_q; // held count
	wire [width-1:0] count_d = clear ? '0 : (step ? width'(count_q + 1'b1) : count_q);
	// count register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) count_q <= '0;
		else count_q <= count_d;
	end
	assign count = count_q;
endmodule : step_counter

// >>> bench/debug_host_model.sv
// host debug system model: serial command pulses and the debug enable level
module debug_host_model (
	input wire logic clock, // bus clock
	output logic debug_enable_bit, // debug enable level
	output logic debug_serial_pin_cmd, // background command pulse
	output logic resume_cmd, // go command pulse
	output logic single_step_command, // trace one command pulse
	output logic tagged_resume_command // tagged go command pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet host at time zero
	initial begin
		debug_enable_bit = 1'b0;
		{debug_serial_pin_cmd, resume_cmd, single_step_command, tagged_resume_command} = 4'h0;
	end
	////////////////////////////////////////////////////////////
	// one command a call, one cycle wide, launched just after an edge
	task automatic pulse(input int kind);
		@(posedge clock) #1;
		case (kind)
			0: debug_serial_pin_cmd = 1'b1;
			1: resume_cmd = 1'b1;
			2: single_step_command = 1'b1;
			default: tagged_resume_command = 1'b1;
		endcase
		@(posedge clock) #1;
		{debug_serial_pin_cmd, resume_cmd, single_step_command, tagged_resume_command} = 4'h0;
	endtask : pulse
	// enable keeps the oscillator alive in stop so a later command can wake it
	task automatic set_enable(input logic en);
		@(posedge clock) #1 debug_enable_bit = en;
	endtask : set_enable
endmodule : debug_host_model

// >>> bench/cpu_operand_address_and_sequencer_test.sv
// self-checking bench for the operand address and sequencer block
module cpu_operand_address_and_sequencer_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, sys_rst, rst_src_done, rst_pin_n, operand_fetched, irq_pending;
	logic instr_boundary, software_trap_instruction, wait_instruction, stop_instruction;
	logic enter_debug_instruction, mask_cleared_prev, reset_into_debug, index_load;
	logic bus_req, bus_we, stack_load, pc_load, set_imask, clear_imask, cpu_clk_gate;
	logic osc_keep_on, in_background, running, debug_enable_bit, debug_serial_pin_cmd, resume_cmd;
	logic single_step_command, tagged_resume_command, cleared;
	logic [4:0] ops; // opcode strobes, bit 0 is the boundary
	seq_pkg::addr_mode_t mode;
	logic [15:0] index_pair, stack_ptr, operand_bytes, operand_addr, index_pair_next;
	logic [15:0] irq_vector_addr, bus_addr, stack_ptr_next, pc_load_value;
	logic [7:0] program_counter_low_byte, program_counter_upper_byte, index_low;
	logic [7:0] accumulator, condition_code_reg, bus_wdata, bus_rdata;
	int errors, comparisons;
	// one row of the addressing table: request beside expected result
	typedef struct packed {
		seq_pkg::addr_mode_t m;
		logic [15:0] ix, sp, ob, ea;
		logic ld;
	} row_t;
	// byte offsets repeat in both halves so either byte choice gives the same sum
	row_t rows [9] = '{
		'{seq_pkg::mode_dir, 16'h1234, 16'h0000, 16'h5a5a, 16'h005a, 1'b0},
		'{seq_pkg::mode_ext, 16'h1234, 16'h0000, 16'hbeef, 16'hbeef, 1'b0},
		'{seq_pkg::mode_ix, 16'h8001, 16'h0000, 16'h0000, 16'h8001, 1'b0},
		'{seq_pkg::mode_ix_inc, 16'hffff, 16'h0000, 16'h0000, 16'hffff, 1'b1},
		'{seq_pkg::mode_ix1, 16'hfff0, 16'h0000, 16'h3030, 16'h0020, 1'b0},
		'{seq_pkg::mode_ix1_inc, 16'h1000, 16'h0000, 16'h8080, 16'h1080, 1'b1},
		'{seq_pkg::mode_ix2, 16'h1000, 16'h0000, 16'hf123, 16'h0123, 1'b0},
		'{seq_pkg::mode_sp1, 16'h0000, 16'h00ff, 16'h8181, 16'h0180, 1'b0},
		'{seq_pkg::mode_sp2, 16'h0000, 16'h8000, 16'h8000, 16'h0000, 1'b0}
	};
	// memory seen by the block: every byte derived from its address
	function automatic logic [7:0] mem(input logic [15:0] a);
		return a[7:0] + 8'h11;
	endfunction : mem
	assign bus_rdata = mem(bus_addr);
	assign {enter_debug_instruction, stop_instruction, wait_instruction} = ops[4:2];
	assign {software_trap_instruction, instr_boundary} = ops[1:0];
	initial clock = 1'b0;
	always #2 clock = ~clock;
	cpu_operand_address_and_sequencer DUT (.clock, .sys_rst, .rst_src_done, .rst_pin_n,
		.mode, .index_pair, .stack_ptr, .operand_bytes, .operand_addr, .operand_fetched,
		.index_load, .index_pair_next, .program_counter_low_byte, .program_counter_upper_byte,
		.index_low, .accumulator, .condition_code_reg, .instr_boundary, .irq_pending,
		.irq_vector_addr, .software_trap_instruction, .wait_instruction, .stop_instruction,
		.enter_debug_instruction, .mask_cleared_prev, .debug_enable_bit, .reset_into_debug,
		.debug_serial_pin_cmd, .resume_cmd, .single_step_command, .tagged_resume_command, .bus_rdata,
		.bus_req, .bus_we, .bus_addr, .bus_wdata, .stack_ptr_next, .stack_load, .pc_load_value,
		.pc_load, .set_imask, .clear_imask, .cpu_clk_gate, .osc_keep_on, .in_background,
		.running);
	debug_host_model host (.clock, .debug_enable_bit, .debug_serial_pin_cmd, .resume_cmd,
		.single_step_command, .tagged_resume_command);
	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// bounded wait on one flag; a hang ends the run at once
	task automatic wait_flag(input int sel);
		logic hit;
		for (int n = 0; n < 40; n++) begin
			@(negedge clock);
			case (sel)
				0: hit = bus_req && bus_we;
				1: hit = bus_req && bus_addr == 16'hfffe;
				2: hit = in_background;
				3: hit = running;
				4: hit = cpu_clk_gate;
				default: hit = clear_imask;
			endcase
			if (hit === 1'b1) return;
		end
		errors++;
		$display("CHECK FAILED flag %0d expected 1 seen 0", sel);
		tally_and_finish();
	endtask : wait_flag
	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clock);
			check("idle bus", bus_req, 1'b0);
		end
	endtask : quiet
	// the boundary with one opcode strobe (none for op 0), held across exactly one edge
	task automatic boundary(input int op);
		@(posedge clock) #1;
		ops = 5'h01 | (5'h01 << op);
		@(negedge clock);
		cleared = clear_imask;
		@(posedge clock) #1;
		ops = 5'h00;
	endtask : boundary
	////////////////////////////////////////////////////////////
	task automatic reset_seq;
		logic [15:0] tgt;
		tgt = {mem(16'hfffe), mem(16'hffff)};
		wait_flag(1);
		@(negedge clock);
		check("vec lo addr", bus_addr, 16'hffff);
		for (int k = 0; k < 3; k++) begin
			@(negedge clock);
			check("fill addr", bus_addr, tgt + 16'(k));
		end
		@(negedge clock);
		check("start pc", pc_load_value, tgt);
		check("start load", pc_load, 1'b1);
		wait_flag(reset_into_debug ? 2 : 3);
	endtask : reset_seq
	// entry walk: five pushes, mask, two vector reads, free cycle, three fills
	task automatic entry_seq;
		logic [7:0] pushed [5];
		logic [15:0] vec, tgt;
		vec = irq_vector_addr;
		tgt = {mem(vec), mem(vec + 16'h0001)};
		pushed = '{program_counter_low_byte, program_counter_upper_byte, index_low,
			accumulator, condition_code_reg};
		wait_flag(0);
		for (int k = 0; k < 5; k++) begin
			if (k > 0) @(negedge clock);
			check("push addr", bus_addr, stack_ptr - 16'(k));
			check("push data", {stack_load, bus_we, bus_wdata}, {8'h03, pushed[k]});
			check("sp next", stack_ptr_next, stack_ptr - 16'(k + 1));
		end
		@(negedge clock);
		check("mask set", {set_imask, bus_we}, 2'b10);
		@(negedge clock);
		check("vec hi", bus_addr, vec);
		@(negedge clock);
		check("vec lo", bus_addr, vec + 16'h0001);
		@(negedge clock);
		check("free cycle", {bus_req, pc_load}, 2'b01);
		check("isr pc", pc_load_value, tgt);
		for (int k = 0; k < 3; k++) begin
			@(negedge clock);
			check("isr fill", bus_addr, tgt + 16'(k));
		end
	endtask : entry_seq
	////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		{rst_src_done, rst_pin_n, operand_fetched, irq_pending, mask_cleared_prev} = 5'h00;
		{reset_into_debug, ops, mode} = {6'h00, seq_pkg::mode_dir};
		{index_pair, stack_ptr, operand_bytes, irq_vector_addr} = 64'h0000_01ff_0000_ffe0;
		{program_counter_low_byte, program_counter_upper_byte} = 16'h2143;
		{index_low, accumulator, condition_code_reg} = 24'h658700;
		repeat (16) @(posedge clock);
		#1 sys_rst = 1'b0;
		quiet(6);
		rst_pin_n = 1'b1;
		rst_src_done = 1'b1;
		reset_seq();
		$display("test reset done");
		foreach (rows[i]) begin
			@(posedge clock) #1;
			{mode, index_pair, stack_ptr} = {rows[i].m, rows[i].ix, rows[i].sp};
			operand_bytes = rows[i].ob;
			operand_fetched = 1'b1;
			@(negedge clock);
			check("operand addr", operand_addr, rows[i].ea);
			check("index load", index_load, rows[i].ld);
			check("index next", index_pair_next, rows[i].ix + 16'h0001);
		end
		@(posedge clock) #1;
		{operand_fetched, stack_ptr} = 17'h001ff;
		$display("test address table done");
		irq_pending = 1'b1;
		quiet(4);
		mask_cleared_prev = 1'b1;
		boundary(0);
		quiet(6);
		{mask_cleared_prev, condition_code_reg} = 9'h008;
		boundary(0);
		quiet(6);
		condition_code_reg = 8'h00;
		boundary(0);
		entry_seq();
		{irq_pending, condition_code_reg, irq_vector_addr} = 25'h008fffc;
		boundary(1);
		entry_seq();
		$display("test interrupt entry done");
		boundary(2);
		check("mask clear", cleared, 1'b1);
		condition_code_reg = 8'h00;
		wait_flag(4);
		host.pulse(0);
		wait_flag(2);
		check("clocks back", cpu_clk_gate, 1'b0);
		host.pulse(1);
		wait_flag(3);
		for (int k = 2; k < 4; k++) begin
			boundary(4);
			wait_flag(2);
			check("halted", running, 1'b0);
			host.pulse(k);
			wait_flag(3);
		end
		boundary(2);
		wait_flag(4);
		irq_pending = 1'b1;
		entry_seq();
		irq_pending = 1'b0;
		host.set_enable(1'b1);
		@(negedge clock);
		check("osc kept", osc_keep_on, 1'b1);
		boundary(3);
		host.pulse(0);
		wait_flag(2);
		host.pulse(1);
		wait_flag(3);
		$display("test low power and debug done");
		boundary(1);
		wait_flag(0);
		#1 {sys_rst, reset_into_debug} = 2'h3;
		#1 check("abandon", {bus_req, running}, 2'b00);
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b0;
		reset_seq();
		$display("test reset in entry done");
		tally_and_finish();
	end
endmodule : cpu_operand_address_and_sequencer_test
